/* ptmr_map.svh */
// register offsets, field positions and reset values of the periodic timer
`ifndef PTMR_MAP_SVH
`define PTMR_MAP_SVH

// ==========================================================================
// register byte offsets
`define PTMR_OFF_CTRL_A     8'h00
`define PTMR_OFF_CTRL_B     8'h04
`define PTMR_OFF_CNT_LO     8'h08
`define PTMR_OFF_CNT_HI     8'h0C
`define PTMR_OFF_CMPA_LO    8'h10
`define PTMR_OFF_CMPA_HI    8'h14
`define PTMR_OFF_PER_LO     8'h18
`define PTMR_OFF_PER_HI     8'h1C
`define PTMR_OFF_IRQ_STAT   8'h20
`define PTMR_OFF_IRQ_MASK   8'h24

// ==========================================================================
// timer_control_a fields
`define PTMR_CA_PAUSE       7
`define PTMR_CA_CLK_MSB     6
`define PTMR_CA_CLK_LSB     4
`define PTMR_CA_RUN         3
`define PTMR_CA_IMPL_MASK   8'hF8

// ==========================================================================
// timer_control_b fields
`define PTMR_CB_MODE_MSB    7
`define PTMR_CB_MODE_LSB    6
`define PTMR_CB_PIN_MSB     5
`define PTMR_CB_PIN_LSB     4
`define PTMR_CB_INIT        3
`define PTMR_CB_INV         2
`define PTMR_CB_CLR_SRC     0

// ==========================================================================
// interrupt status and mask fields
`define PTMR_IRQ_W          3
`define PTMR_IRQ_MATCH_A    0
`define PTMR_IRQ_MATCH_P    1
`define PTMR_IRQ_OVF        2

// ==========================================================================
// reset values, counter maximum and prescale terminal counts
`define PTMR_CTRL_RST       8'h00
`define PTMR_VAL_RST        10'h000
`define PTMR_CNT_MAX        10'h3FF
`define PTMR_DIV4_TERM      6'h03
`define PTMR_DIV16_TERM     6'h0F
`define PTMR_DIV64_TERM     6'h3F

`endif

/* ptmr_pkg.sv */
// types shared by the periodic timer modules
package ptmr_pkg;

    // ======================================================================
    // operating mode field
    typedef enum logic [1:0] {
        PTMR_MODE_CMP   = 2'b00,
        PTMR_MODE_UNDEF = 2'b01,
        PTMR_MODE_PWM   = 2'b10,
        PTMR_MODE_TMR   = 2'b11
    } ptmr_mode_type;

    // ======================================================================
    // count clock selection field
    typedef enum logic [2:0] {
        PTMR_CLK_SYS4   = 3'b000,
        PTMR_CLK_SYS    = 3'b001,
        PTMR_CLK_H16    = 3'b010,
        PTMR_CLK_H64    = 3'b011,
        PTMR_CLK_SUB_A  = 3'b100,
        PTMR_CLK_SUB_B  = 3'b101,
        PTMR_CLK_EXT_R  = 3'b110,
        PTMR_CLK_EXT_F  = 3'b111
    } ptmr_clk_sel_type;

endpackage

/* ptmr_edge_sync.sv */
// two-flop synchroniser with registered rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none

module ptmr_edge_sync (
    // clock and reset
    input  wire logic   core_clk_in,
    input  wire logic   rst_n_in,
    // asynchronous level
    input  wire logic   async_in,
    // edge pulses
    output var  logic   rise_out,
    output var  logic   fall_out
);

    logic   meta_r;
    logic   sync_r;
    logic   last_r;
    logic   rise_r;
    logic   fall_r;
    logic   rise_nxt;
    logic   fall_nxt;

    // ======================================================================
    // edge detection looks only at the second stage
    always_comb begin
        rise_nxt = sync_r & ~last_r;
        fall_nxt = ~sync_r & last_r;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign rise_out = rise_r;
    assign fall_out = fall_r;

endmodule // ptmr_edge_sync

`default_nettype wire

/* ptmr_prescale.sv */
// count clock selection: divided system clock, sub clock or external edges
`timescale 1ns/10ps
`default_nettype none
`include "ptmr_map.svh"

module ptmr_prescale (
    // clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_n_in,
    // control
    input  wire logic                       enable_in,
    input  wire ptmr_pkg::ptmr_clk_sel_type sel_in,
    // synchronised edge events
    input  wire logic                       sub_rise_in,
    input  wire logic                       ext_rise_in,
    input  wire logic                       ext_fall_in,
    // one-cycle count tick
    output var  logic                       tick_out
);
    import ptmr_pkg::*;

    logic [5:0] div_r;
    logic [5:0] div_nxt;
    logic       tick_r;
    logic       tick_nxt;

    // ======================================================================
    // divider is held at zero while off so the stopped timer draws no toggle
    always_comb begin
        div_nxt  = enable_in ? div_r + 6'h01 : 6'h00;
        tick_nxt = 1'b0;
        if (enable_in) begin
            case (sel_in)
                PTMR_CLK_SYS4:  tick_nxt = div_r[1:0] == 2'(`PTMR_DIV4_TERM);
                PTMR_CLK_SYS:   tick_nxt = 1'b1;
                PTMR_CLK_H16:   tick_nxt = div_r[3:0] == 4'(`PTMR_DIV16_TERM);
                PTMR_CLK_H64:   tick_nxt = div_r == `PTMR_DIV64_TERM;
                PTMR_CLK_SUB_A: tick_nxt = sub_rise_in;
                PTMR_CLK_SUB_B: tick_nxt = sub_rise_in;
                PTMR_CLK_EXT_R: tick_nxt = ext_rise_in;
                PTMR_CLK_EXT_F: tick_nxt = ext_fall_in;
                default:        tick_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r  <= 6'h00;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;

endmodule // ptmr_prescale

`default_nettype wire

/* ptmr_timer.sv */
// periodic timer top: APB registers, 10-bit counter, output pin, interrupt
`timescale 1ns/10ps
`default_nettype none
`include "ptmr_map.svh"

module ptmr_timer (
    // clock and reset
    input  wire logic           core_clk_in,
    input  wire logic           rst_n_in,
    // apb slave
    input  wire logic [7:0]     paddr_in,
    input  wire logic           psel_in,
    input  wire logic           penable_in,
    input  wire logic           pwrite_in,
    input  wire logic [31:0]    pwdata_in,
    output var  logic [31:0]    prdata_out,
    output var  logic           pready_out,
    output var  logic           pslverr_out,
    // timer pins
    input  wire logic           external_count_input_in,
    input  wire logic           sub_clock_in,
    output var  logic           timer_output_pin_out,
    output var  logic           timer_output_pin_oe_out,
    // interrupt
    output var  logic           timer_irq_out
);
    import ptmr_pkg::*;

    // ======================================================================
    // declarations
    logic [7:0]             ctrl_a_r;
    logic [7:0]             ctrl_a_nxt;
    logic [7:0]             ctrl_b_r;
    logic [7:0]             ctrl_b_nxt;
    logic [9:0]             cmp_a_r;
    logic [9:0]             cmp_a_nxt;
    logic [9:0]             per_r;
    logic [9:0]             per_nxt;
    logic [`PTMR_IRQ_W-1:0] stat_r;
    logic [`PTMR_IRQ_W-1:0] stat_nxt;
    logic [`PTMR_IRQ_W-1:0] mask_r;
    logic [`PTMR_IRQ_W-1:0] mask_nxt;
    logic                   irq_r;
    logic                   irq_nxt;
    logic [31:0]            prdata_r;
    logic [31:0]            prdata_nxt;
    logic                   pready_r;
    logic                   pready_nxt;
    logic                   pslverr_r;
    logic                   pslverr_nxt;

    logic [9:0]             cnt_r;
    logic [9:0]             cnt_nxt;
    logic                   run_d_r;
    logic                   run_d_nxt;
    logic                   pin_r;
    logic                   pin_nxt;
    logic                   out_r;
    logic                   out_nxt;
    logic                   oe_r;
    logic                   oe_nxt;

    logic                   run;
    logic                   paused;
    logic                   inv;
    logic                   init_lvl;
    logic                   clr_src;
    logic [1:0]             pin_fn;
    ptmr_mode_type          mode;
    ptmr_clk_sel_type       clk_sel;
    logic                   tick;
    logic                   sub_rise;
    logic                   ext_rise;
    logic                   ext_fall;
    logic                   run_rise;
    logic                   counting;
    logic                   hit_a;
    logic                   hit_p;
    logic                   ovf;
    logic                   cnt_clear;
    logic                   sp_mode;
    logic                   sp_stop;
    logic                   setup;
    logic                   wr_en;

    // ======================================================================
    // address decode shared by write and error paths
    function automatic logic ptmr_mapped(input logic [7:0] addr);
        case (addr)
            `PTMR_OFF_CTRL_A, `PTMR_OFF_CTRL_B,
            `PTMR_OFF_CNT_LO, `PTMR_OFF_CNT_HI,
            `PTMR_OFF_CMPA_LO, `PTMR_OFF_CMPA_HI,
            `PTMR_OFF_PER_LO, `PTMR_OFF_PER_HI,
            `PTMR_OFF_IRQ_STAT, `PTMR_OFF_IRQ_MASK: ptmr_mapped = 1'b1;
            default:                                ptmr_mapped = 1'b0;
        endcase
    endfunction

    // ======================================================================
    // synchronisers and count clock
    ptmr_edge_sync u_ext_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .async_in    (external_count_input_in),
        .rise_out    (ext_rise),
        .fall_out    (ext_fall)
    );

    ptmr_edge_sync u_sub_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .async_in    (sub_clock_in),
        .rise_out    (sub_rise),
        .fall_out    ()
    );

    ptmr_prescale u_prescale (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .enable_in   (run),
        .sel_in      (clk_sel),
        .sub_rise_in (sub_rise),
        .ext_rise_in (ext_rise),
        .ext_fall_in (ext_fall),
        .tick_out    (tick)
    );

    // ======================================================================
    // field extraction and counter events
    always_comb begin
        run      = ctrl_a_r[`PTMR_CA_RUN];
        paused   = ctrl_a_r[`PTMR_CA_PAUSE];
        clk_sel  = ptmr_clk_sel_type'(
                   ctrl_a_r[`PTMR_CA_CLK_MSB:`PTMR_CA_CLK_LSB]);
        mode     = ptmr_mode_type'(
                   ctrl_b_r[`PTMR_CB_MODE_MSB:`PTMR_CB_MODE_LSB]);
        pin_fn   = ctrl_b_r[`PTMR_CB_PIN_MSB:`PTMR_CB_PIN_LSB];
        init_lvl = ctrl_b_r[`PTMR_CB_INIT];
        inv      = ctrl_b_r[`PTMR_CB_INV];
        clr_src  = ctrl_b_r[`PTMR_CB_CLR_SRC];
        run_rise = run & ~run_d_r;
        counting = run & ~paused & tick & ~run_rise;
        hit_a    = counting & (cnt_r == cmp_a_r);
        hit_p    = counting & (cnt_r == per_r);
        ovf      = counting & (cnt_r == `PTMR_CNT_MAX);
        sp_mode  = (mode == PTMR_MODE_PWM) & (pin_fn == 2'b11);
        sp_stop  = sp_mode & hit_a;
        if (mode == PTMR_MODE_PWM) begin
            cnt_clear = sp_mode ? 1'b0 : hit_p;
        end else begin
            cnt_clear = clr_src ? hit_a : hit_p;
        end
    end

    // ======================================================================
    // counter and output pin
    always_comb begin
        cnt_nxt   = cnt_r;
        pin_nxt   = pin_r;
        run_d_nxt = run;
        if (run_rise) begin
            cnt_nxt = `PTMR_VAL_RST;
        end else if (counting) begin
            cnt_nxt = cnt_clear ? `PTMR_VAL_RST : cnt_r + 10'h001;
        end
        case (mode)
            PTMR_MODE_CMP: begin
                if (run_rise) begin
                    pin_nxt = init_lvl;
                end else if (hit_a) begin
                    case (pin_fn)
                        2'b01:   pin_nxt = 1'b0;
                        2'b10:   pin_nxt = 1'b1;
                        2'b11:   pin_nxt = ~pin_r;
                        default: pin_nxt = pin_r;
                    endcase
                end
            end
            PTMR_MODE_PWM: begin
                case (pin_fn)
                    2'b00:   pin_nxt = ~init_lvl;
                    2'b01:   pin_nxt = init_lvl;
                    2'b10:   pin_nxt = (run & (cnt_nxt < cmp_a_r)) ?
                                       init_lvl : ~init_lvl;
                    2'b11: begin
                        if (run_rise) begin
                            pin_nxt = init_lvl;
                        end else if (sp_stop | ~run) begin
                            pin_nxt = ~init_lvl;
                        end
                    end
                    default: pin_nxt = pin_r;
                endcase
            end
            default: pin_nxt = pin_r;
        endcase
        oe_nxt  = (mode == PTMR_MODE_CMP) | (mode == PTMR_MODE_PWM);
        out_nxt = oe_nxt ? (pin_nxt ^ inv) : 1'b0;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r   <= `PTMR_VAL_RST;
            run_d_r <= 1'b0;
            pin_r   <= 1'b0;
            out_r   <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            run_d_r <= run_d_nxt;
            pin_r   <= pin_nxt;
            out_r   <= out_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // ======================================================================
    // apb register file and interrupt
    always_comb begin
        setup       = psel_in & ~penable_in;
        wr_en       = psel_in & penable_in & pready_r & pwrite_in
                      & ptmr_mapped(paddr_in);
        ctrl_a_nxt  = ctrl_a_r;
        ctrl_b_nxt  = ctrl_b_r;
        cmp_a_nxt   = cmp_a_r;
        per_nxt     = per_r;
        mask_nxt    = mask_r;
        stat_nxt    = stat_r;
        // single pulse ends itself on an A match; a software write wins
        if (sp_stop) begin
            ctrl_a_nxt[`PTMR_CA_RUN] = 1'b0;
        end
        if (wr_en) begin
            case (paddr_in)
                `PTMR_OFF_CTRL_A:   ctrl_a_nxt = pwdata_in[7:0]
                                                 & `PTMR_CA_IMPL_MASK;
                `PTMR_OFF_CTRL_B:   ctrl_b_nxt = pwdata_in[7:0];
                `PTMR_OFF_CMPA_LO:  cmp_a_nxt[7:0] = pwdata_in[7:0];
                `PTMR_OFF_CMPA_HI:  cmp_a_nxt[9:8] = pwdata_in[1:0];
                `PTMR_OFF_PER_LO:   per_nxt[7:0] = pwdata_in[7:0];
                `PTMR_OFF_PER_HI:   per_nxt[9:8] = pwdata_in[1:0];
                `PTMR_OFF_IRQ_STAT: stat_nxt = stat_r
                                    & ~pwdata_in[`PTMR_IRQ_W-1:0];
                `PTMR_OFF_IRQ_MASK: mask_nxt = pwdata_in[`PTMR_IRQ_W-1:0];
                default:            ctrl_b_nxt = ctrl_b_r;
            endcase
        end
        // events set flags; set beats clear
        stat_nxt[`PTMR_IRQ_MATCH_A] = stat_nxt[`PTMR_IRQ_MATCH_A] | hit_a;
        stat_nxt[`PTMR_IRQ_MATCH_P] = stat_nxt[`PTMR_IRQ_MATCH_P] | hit_p;
        stat_nxt[`PTMR_IRQ_OVF]     = stat_nxt[`PTMR_IRQ_OVF] | ovf;
        irq_nxt     = |(stat_r & mask_r);
        // read data is captured in the setup cycle, ready in the access
        pready_nxt  = setup;
        pslverr_nxt = setup & ~ptmr_mapped(paddr_in);
        prdata_nxt  = prdata_r;
        if (setup) begin
            case (paddr_in)
                `PTMR_OFF_CTRL_A:   prdata_nxt = {24'h000000, ctrl_a_r};
                `PTMR_OFF_CTRL_B:   prdata_nxt = {24'h000000, ctrl_b_r};
                `PTMR_OFF_CNT_LO:   prdata_nxt = {24'h000000, cnt_r[7:0]};
                `PTMR_OFF_CNT_HI:   prdata_nxt = {30'h0, cnt_r[9:8]};
                `PTMR_OFF_CMPA_LO:  prdata_nxt = {24'h000000, cmp_a_r[7:0]};
                `PTMR_OFF_CMPA_HI:  prdata_nxt = {30'h0, cmp_a_r[9:8]};
                `PTMR_OFF_PER_LO:   prdata_nxt = {24'h000000, per_r[7:0]};
                `PTMR_OFF_PER_HI:   prdata_nxt = {30'h0, per_r[9:8]};
                `PTMR_OFF_IRQ_STAT: prdata_nxt = {29'h0, stat_r};
                `PTMR_OFF_IRQ_MASK: prdata_nxt = {29'h0, mask_r};
                default:            prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_a_r  <= `PTMR_CTRL_RST;
            ctrl_b_r  <= `PTMR_CTRL_RST;
            cmp_a_r   <= `PTMR_VAL_RST;
            per_r     <= `PTMR_VAL_RST;
            stat_r    <= {`PTMR_IRQ_W{1'b0}};
            mask_r    <= {`PTMR_IRQ_W{1'b0}};
            irq_r     <= 1'b0;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_a_r  <= ctrl_a_nxt;
            ctrl_b_r  <= ctrl_b_nxt;
            cmp_a_r   <= cmp_a_nxt;
            per_r     <= per_nxt;
            stat_r    <= stat_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= irq_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ======================================================================
    // outputs, all straight from flip-flops
    assign prdata_out              = prdata_r;
    assign pready_out              = pready_r;
    assign pslverr_out             = pslverr_r;
    assign timer_output_pin_out    = out_r;
    assign timer_output_pin_oe_out = oe_r;
    assign timer_irq_out           = irq_r;

endmodule // ptmr_timer

`default_nettype wire

/* ptmr_timer_assertions.sv */
// port assertions for the periodic timer, with their bind
`timescale 1ns/10ps
`default_nettype none
module ptmr_timer_assertions (
    // clock, reset and apb
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  paddr_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // pin and interrupt
    input wire logic        timer_output_pin_out,
    input wire logic        timer_output_pin_oe_out,
    input wire logic        timer_irq_out
);
    // ======================================================================
    // properties
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic rd_w = pready_out && !pwrite_in;
    wire logic wb_w = pready_out && pwrite_in && paddr_in == 8'h04;
    property p_answer; psel_in && !penable_in |=> pready_out; endproperty
    a_answer: assert property (p_answer) else $error("setup not answered");
    property p_single; pready_out |=> !pready_out; endproperty
    a_single: assert property (p_single) else $error("pready held too long");
    property p_unmap;
        pready_out && paddr_in[1:0] == 2'b00
            |-> pslverr_out == (paddr_in > 8'h24);
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("wrong slave error");
    property p_ctrl_rd;
        rd_w && paddr_in == 8'h00 |-> prdata_out[2:0] == 3'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("bits 2:0 set");
    property p_cnt_hi;
        rd_w && paddr_in == 8'h0C |-> prdata_out[31:2] == 30'h0;
    endproperty
    a_cnt_hi: assert property (p_cnt_hi)
        else $error("count too wide");
    property p_tmr_oe;
        wb_w && pwdata_in[7:6] == 2'b11
            |-> ##[1:3] !timer_output_pin_oe_out;
    endproperty
    a_tmr_oe: assert property (p_tmr_oe)
        else $error("pin still driven");
    property p_cmp_oe;
        wb_w && pwdata_in[7:6] == 2'b00
            |-> ##[1:3] timer_output_pin_oe_out;
    endproperty
    a_cmp_oe: assert property (p_cmp_oe)
        else $error("pin not driven");
    property p_pin_off;
        !timer_output_pin_oe_out |-> !timer_output_pin_out;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("idle pin high");
    property p_mask_off;
        pready_out && pwrite_in && paddr_in == 8'h24
            && pwdata_in[2:0] == 3'h0 |-> ##2 !timer_irq_out;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("masked irq");
    c_err: cover property (pready_out && pslverr_out);
    c_irq: cover property ($rose(timer_irq_out));
    c_pin: cover property ($fell(timer_output_pin_out));
endmodule // ptmr_timer_assertions
bind ptmr_timer ptmr_timer_assertions u_chk (.core_clk_in, .rst_n_in,
    .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .timer_output_pin_out,
    .timer_output_pin_oe_out, .timer_irq_out);
`default_nettype wire

/* ptmr_timer_tb.sv */
// self-checking bench for the periodic timer
`timescale 1ns/10ps
`default_nettype none
module ptmr_timer_tb;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, ext = 1'b0, sub = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, v, c1;
    logic        rdy, err, pin, oe, irq, se;
    int          errors = 0;
    int          tests_run = 0;
    always #12.5 clk = ~clk;
    ptmr_timer dut (.core_clk_in(clk), .rst_n_in(rst_n), .paddr_in(pa),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
        .external_count_input_in(ext), .sub_clock_in(sub),
        .timer_output_pin_out(pin), .timer_output_pin_oe_out(oe),
        .timer_irq_out(irq));
    // ======================================================================
    // bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        pa <= a;
        pwr <= w;
        pwd <= d;
        psel <= 1'b1;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // only the watchdog ends a wait for ready
        while (rdy !== 1'b1) begin
            @(posedge clk);
        end
        chk(rdy, 1'b1);
        v = prd;
        se = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(v, e);
    endtask
    task automatic pinc(input int n, input logic e);
        repeat (n) @(posedge clk);
        #1;
        chk(pin, e);
    endtask
    // ======================================================================
    // scenarios
    task automatic t_regs;
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        wr(8'h00, 32'hFF);
        rdc(8'h00, 32'hF8);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'hFF);
        rdc(8'h08, 32'h0);
        rdc(8'h0C, 32'h0);
        wr(8'h14, 32'hFF);
        rdc(8'h14, 32'h3);
        wr(8'h14, 32'h0);
        wr(8'h1C, 32'h3);
        wr(8'h18, 32'hFF);
        rdc(8'h30, 32'h0);
        chk(se, 1'b1);
        $display("register test done");
    endtask
    task automatic t_count;
        wr(8'h00, 32'h18);
        repeat (20) @(posedge clk);
        wr(8'h00, 32'h98);
        apb(8'h08, 1'b0, 32'h0);
        c1 = v;
        repeat (10) @(posedge clk);
        rdc(8'h08, c1);
        wr(8'h00, 32'h18);
        repeat (5) @(posedge clk);
        apb(8'h08, 1'b0, 32'h0);
        chk(v > c1, 1'b1);
        wr(8'h00, 32'h10);
        apb(8'h08, 1'b0, 32'h0);
        c1 = v;
        repeat (10) @(posedge clk);
        rdc(8'h08, c1);
        wr(8'h00, 32'h18);
        apb(8'h08, 1'b0, 32'h0);
        chk(v < 8, 1'b1);
        $display("count test done");
    endtask
    task automatic t_cmp;
        logic [1:0] fn;
        logic       ini, e;
        wr(8'h10, 32'h5);
        for (int i = 0; i < 8; i++) begin
            fn = i[2:1];
            ini = i[0];
            e = (fn == 2'b00) ? ini : (fn == 2'b11) ? !ini : fn[1];
            wr(8'h00, 32'h0);
            wr(8'h04, {26'h0, fn, ini, 3'h0});
            wr(8'h00, 32'h08);
            pinc(2, ini);
            pinc(40, e);
        end
        $display("compare test done");
    endtask
    task automatic t_pwm;
        logic [7:0] cb [3] = '{8'h88, 8'h98, 8'h9C};
        logic       ex [3] = '{1'b0, 1'b1, 1'b0};
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, 32'h0);
            wr(8'h04, {24'h0, cb[k]});
            wr(8'h00, 32'h08);
            pinc(4, ex[k]);
        end
        wr(8'h00, 32'h0);
        wr(8'h04, 32'hC0);
        pinc(4, 1'b0);
        chk(oe, 1'b0);
        wr(8'h04, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        chk(oe, 1'b1);
        wr(8'h04, 32'h40);
        #1;
        chk(oe, 1'b0);
        wr(8'h04, 32'h0);
        $display("pwm test done");
    endtask
    task automatic t_clk;
        // divided system clock: each read lands mid-way between the second and third tick
        for (int k = 2; k < 4; k++) begin
            wr(8'h00, 32'h0);
            wr(8'h00, {24'h0, 1'b0, k[2:0], 4'h8});
            repeat ((k == 2) ? 40 : 160) @(posedge clk);
            rdc(8'h08, 32'h2);
        end
        for (int k = 5; k < 8; k++) begin
            wr(8'h00, 32'h0);
            wr(8'h00, {24'h0, 1'b0, k[2:0], 4'h8});
            repeat (5) begin
                ext <= 1'b1;
                sub <= 1'b1;
                repeat (6) @(posedge clk);
                ext <= 1'b0;
                sub <= 1'b0;
                repeat (6) @(posedge clk);
            end
            rdc(8'h08, 32'h5);
        end
        $display("clock source test done");
    endtask
    task automatic t_irq;
        wr(8'h20, 32'h7);
        rdc(8'h20, 32'h0);
        wr(8'h24, 32'h1);
        wr(8'h00, 32'h18);
        repeat (12) @(posedge clk);
        chk(irq, 1'b1);
        rdc(8'h20, 32'h1);
        wr(8'h24, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h18);
        repeat (30) @(posedge clk);
        apb(8'h08, 1'b0, 32'h0);
        chk(v < 6, 1'b1);
        $display("interrupt test done");
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_count;
        t_cmp;
        t_pwm;
        t_clk;
        t_irq;
        stop_test;
    end
    // watchdog well past the thousand-odd cycles the scenarios need
    initial begin
        repeat (10000) @(posedge clk);
        chk(1'b0, 1'b1);
        stop_test;
    end
endmodule // ptmr_timer_tb
`default_nettype wire
